//--- core/ipp_consts.svh
`ifndef IPP_CONSTS_SVH
`define IPP_CONSTS_SVH

`define IPP_NSRC          8
`define IPP_OFS_VECTOR    6'h00
`define IPP_OFS_PROTECT   6'h01
`define IPP_OFS_PMODE2    6'h02
`define IPP_OFS_PORT8     6'h03
`define IPP_OFS_CLKCTL0   6'h04
`define IPP_OFS_CLKCTL1   6'h05
`define IPP_OFS_NMIDEB    6'h06
`define IPP_OFS_USP       6'h07
`define IPP_OFS_ISP       6'h08
`define IPP_OFS_STATUS    6'h09
`define IPP_OFS_ICR0      6'h10
`define IPP_BIT_UNLOCK    0
`define IPP_BIT_NMI_EN    4
`define IPP_BIT_NMI_LVL   5
`define IPP_BIT_WAIT_PSTP 2
`define IPP_BIT_CLK_MAIN  7
`define IPP_BIT_ALLSTOP   0
`define IPP_ICR_IR        3
`define IPP_ICR_POL       4
`define IPP_NONMASKABLE_DEBOUNCE_REG_RESET    8'hFF
`define IPP_NONMASKABLE_DEBOUNCE_REG_BYPASS   8'hFF
`define IPP_SP_RESET      16'h0000
`define IPP_SUBDIV_MAX    5'h1F

`endif

//--- core/ipp_pkg.sv
package ipp_pkg;
    typedef logic [2:0] ipp_lvl_t;
    typedef logic [7:0] ipp_src_t;

    typedef struct packed {
        logic [1:0]  nmi_sy;
        ipp_src_t    src_s1;
        ipp_src_t    src_s2;
        ipp_src_t    src_q;
        logic        nmi_f;
        logic        nmi_fq;
        logic [7:0]  dcnt;
        logic        unlock;
        logic        nmi_en;
        logic        wait_peripheral_clock_stop_bit;
        logic        clk_main;
        logic        stop;
        logic        wait_m;
        logic        stall;
        logic        nmi_req;
        logic [7:0]  nonmaskable_debounce_reg;
        ipp_src_t    ir;
        ipp_src_t    pol;
        logic [7:0][2:0] ilvl;
        logic [15:0] user_stack_pointer;
        logic [15:0] interrupt_stack_pointer;
        logic [4:0]  fdiv;
        logic        sub_en;
        logic        wr_pend;
        logic [5:0]  wr_idx;
        logic [31:0] rdata;
        logic        irq_req;
        ipp_lvl_t    irq_num;
        ipp_lvl_t    irq_lvl;
        logic        periph_en;
        logic        cpu_clk_en;
        logic        io_hold;
    } ipp_state_s;
endpackage : ipp_pkg

//--- core/ipp_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "ipp_consts.svh"

// Functional notes
// - unlock bit clears on next write anywhere
// - acknowledge read of vector clears accepted flag
// - program read of vector clears highest flag
// - both stack pointers reset to zero
// - nonmaskable enable sticky until reset
// - nonmaskable pin level readable in port bit
// - pin low forces all-clock-stop bit zero
// - pin low stalls CPU until interrupt
// - debounce value FF bypasses filter
// - source or polarity change may set flag
// - reset exit runs from on-chip oscillator
// - all-clock-stop write enters stop mode
// - wait peripheral stop gates; subclock runs
// - ports held during wait and stop
module ipp_core (
    input  wire logic               hclk,
    input  wire logic               hresetn,
    input  wire logic               hsel,
    input  wire logic [31:0]        haddr,
    input  wire logic [1:0]         htrans,
    input  wire logic               hwrite,
    input  wire logic [2:0]         hsize,
    input  wire logic [31:0]        hwdata,
    input  wire logic               hready,
    output logic [31:0]             hrdata,
    output logic                    hreadyout,
    output logic                    hresp,
    input  wire ipp_pkg::ipp_src_t  irq_src,
    input  wire logic               nmi_pin_n,
    input  wire logic               nmi_ack,
    input  wire logic               cpu_wait,
    output logic                    irq_req,
    output ipp_pkg::ipp_lvl_t       irq_num,
    output ipp_pkg::ipp_lvl_t       irq_lvl,
    output logic                    nmi_req,
    output logic                    cpu_stall,
    output logic                    cpu_clk_en,
    output logic                    periph_clk_en,
    output logic                    subclk_div_en,
    output logic                    onchip_osc_sel,
    output logic                    io_hold,
    output logic                    stop_mode,
    output logic                    wait_mode
);
    import ipp_pkg::*;

    ipp_state_s st;
    ipp_state_s next_st;

    // Highest level wins; lower index breaks ties
    // Level zero masks a source entirely
    function automatic logic [3:0] pick_top(input ipp_src_t ir,
                                            input logic [7:0][2:0] lv);
        logic [2:0] best_l;
        logic [3:0] res;
        best_l = 3'h0;
        res    = 4'h0;
        for (int i = `IPP_NSRC - 1; i >= 0; i--) begin
            if (ir[i] && lv[i] != 3'h0 && lv[i] >= best_l) begin
                best_l = lv[i];
                res    = {1'b1, 3'(i)};
            end
        end
        return res;
    endfunction : pick_top

    // Interrupt control words sit at eight consecutive indices
    function automatic logic is_icr(input logic [5:0] idx);
        return (idx & 6'h38) == `IPP_OFS_ICR0;
    endfunction : is_icr

    logic [3:0]  top;
    logic        acc;
    logic [5:0]  a_idx;
    logic [31:0] rd;
    ipp_src_t    edge_set;
    logic        nmi_fall;
    logic        wr_now;
    logic [2:0]  wi;
    logic        wake;

    always_comb begin
        next_st  = st;
        top      = pick_top(st.ir, st.ilvl);
        acc      = hsel && hready && htrans[1];
        a_idx    = haddr[7:2];
        wr_now   = st.wr_pend;
        wi       = st.wr_idx[2:0];
        rd       = 32'h0000_0000;

        // Two flops before any logic sees a pin
        next_st.nmi_sy = {st.nmi_sy[0], nmi_pin_n};
        next_st.src_s1 = irq_src;
        next_st.src_s2 = st.src_s1;

        // Filter: level must stay nonmaskable_debounce_reg+1 cycles to pass
        // A glitch back to the old level restarts the count
        // Bypass passes the pin straight on, for wake from stop
        if (st.nonmaskable_debounce_reg == `IPP_NONMASKABLE_DEBOUNCE_REG_BYPASS) begin
            next_st.nmi_f = st.nmi_sy[1];
            next_st.dcnt  = 8'h00;
        end else if (st.nmi_sy[1] == st.nmi_f) begin
            next_st.dcnt  = 8'h00;
        end else if (st.dcnt >= st.nonmaskable_debounce_reg) begin
            next_st.nmi_f = st.nmi_sy[1];
            next_st.dcnt  = 8'h00;
        end else begin
            next_st.dcnt  = st.dcnt + 8'h01;
        end
        next_st.nmi_fq = st.nmi_f;
        nmi_fall = st.nmi_en && st.nmi_fq && !st.nmi_f;

        // Polarity is applied before the edge detect, so a
        // polarity flip alone looks like a fresh edge
        next_st.src_q = st.src_s2 ^ st.pol;
        edge_set      = (st.src_s2 ^ st.pol) & ~st.src_q;

        // Bus read answered from the address phase
        if (acc && !hwrite) begin
            case (a_idx)
                `IPP_OFS_VECTOR: begin
                    // Vector word: number in [2:0], level in [6:4]
                    // A program read cancels a request just as an
                    // acknowledge does; the bus cannot tell them apart
                    rd = {25'h0, st.ilvl[top[2:0]], 1'b0, top[2:0]};
                    if (top[3]) begin
                        next_st.ir[top[2:0]] = 1'b0;
                    end
                end
                `IPP_OFS_PROTECT: rd[`IPP_BIT_UNLOCK]   = st.unlock;
                `IPP_OFS_PMODE2:  rd[`IPP_BIT_NMI_EN]   = st.nmi_en;
                `IPP_OFS_PORT8:   rd[`IPP_BIT_NMI_LVL]  = st.nmi_sy[1];
                `IPP_OFS_CLKCTL0: begin
                    rd[`IPP_BIT_WAIT_PSTP] = st.wait_peripheral_clock_stop_bit;
                    rd[`IPP_BIT_CLK_MAIN]  = st.clk_main;
                end
                `IPP_OFS_CLKCTL1: rd[`IPP_BIT_ALLSTOP] = st.stop;
                `IPP_OFS_NMIDEB:  rd[7:0]  = st.nonmaskable_debounce_reg;
                `IPP_OFS_USP:     rd[15:0] = st.user_stack_pointer;
                `IPP_OFS_ISP:     rd[15:0] = st.interrupt_stack_pointer;
                `IPP_OFS_STATUS:  rd[3:0]  = {st.nmi_req, st.stall,
                                              st.wait_m, st.stop};
                default: begin
                    if (is_icr(a_idx)) begin
                        rd[2:0]          = st.ilvl[a_idx[2:0]];
                        rd[`IPP_ICR_IR]  = st.ir[a_idx[2:0]];
                        rd[`IPP_ICR_POL] = st.pol[a_idx[2:0]];
                    end
                end
            endcase
        end
        next_st.rdata   = rd;
        // Write data follows its address by one cycle
        next_st.wr_pend = acc && hwrite;
        next_st.wr_idx  = a_idx;

        // Data-phase write
        if (wr_now) begin
            next_st.unlock = 1'b0;
            case (st.wr_idx)
                `IPP_OFS_PROTECT:
                    next_st.unlock = hwdata[`IPP_BIT_UNLOCK];
                `IPP_OFS_PMODE2: begin
                    if (st.unlock && hwdata[`IPP_BIT_NMI_EN]) begin
                        next_st.nmi_en = 1'b1;
                    end
                end
                `IPP_OFS_CLKCTL0: begin
                    next_st.wait_peripheral_clock_stop_bit     = hwdata[`IPP_BIT_WAIT_PSTP];
                    next_st.clk_main = hwdata[`IPP_BIT_CLK_MAIN];
                end
                `IPP_OFS_CLKCTL1: begin
                    // Prefetched code may still run before stop bites
                    if (hwdata[`IPP_BIT_ALLSTOP]) begin
                        next_st.stop = 1'b1;
                    end
                end
                `IPP_OFS_NMIDEB:  next_st.nonmaskable_debounce_reg = hwdata[7:0];
                `IPP_OFS_USP:     next_st.user_stack_pointer  = hwdata[15:0];
                `IPP_OFS_ISP:     next_st.interrupt_stack_pointer  = hwdata[15:0];
                default: begin
                    if (is_icr(st.wr_idx)) begin
                        next_st.ilvl[wi] = hwdata[2:0];
                        next_st.ir[wi]   = hwdata[`IPP_ICR_IR];
                        next_st.pol[wi]  = hwdata[`IPP_ICR_POL];
                    end
                end
            endcase
        end

        // Hardware set beats any clear in the same cycle
        next_st.ir = next_st.ir | edge_set;
        if (nmi_ack) begin
            next_st.nmi_req = 1'b0;
        end
        // Core clock keeps running while stalled; only the
        // instruction stream halts until the next request
        if (nmi_fall) begin
            next_st.nmi_req = 1'b1;
            next_st.stall   = 1'b1;
        end else if (nmi_ack || st.irq_req) begin
            next_st.stall   = 1'b0;
        end

        // Low pin holds the stop bit at zero
        // Checked after the write, so a stop request loses
        if (st.nmi_en && !st.nmi_f) begin
            next_st.stop = 1'b0;
        end

        // Any request brings the core out of stop or wait
        // A pending request also refuses entry to either mode
        wake = top[3] || nmi_fall || st.nmi_req;
        if (wake) begin
            next_st.stop   = 1'b0;
            next_st.wait_m = 1'b0;
        end else if (cpu_wait) begin
            next_st.wait_m = 1'b1;
        end

        // Sub-clock divider keeps ticking in wait, not in stop
        // Divider phase is kept across stop, not restarted
        if (st.stop) begin
            next_st.sub_en = 1'b0;
        end else begin
            next_st.fdiv   = st.fdiv + 5'h01;
            next_st.sub_en = (st.fdiv == `IPP_SUBDIV_MAX);
        end

        next_st.irq_req    = top[3];
        next_st.irq_num    = top[2:0];
        next_st.irq_lvl    = st.ilvl[top[2:0]];
        next_st.cpu_clk_en = !next_st.stop && !next_st.wait_m;
        next_st.periph_en  = !next_st.stop &&
                             !(next_st.wait_m && st.wait_peripheral_clock_stop_bit);
        next_st.io_hold    = next_st.stop || next_st.wait_m;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st            <= '0;
            // Synchroniser idles high, so no false edge on exit
            st.nmi_sy     <= 2'h3;
            st.src_s1     <= 8'h00;
            st.unlock     <= 1'b0;
            st.stop       <= 1'b0;
            st.wait_m     <= 1'b0;
            st.stall      <= 1'b0;
            st.nmi_req    <= 1'b0;
            st.irq_req    <= 1'b0;
            st.io_hold    <= 1'b0;
            st.ir         <= 8'h00;
            st.pol        <= 8'h00;
            st.rdata      <= 32'h0000_0000;
            st.nmi_f      <= 1'b1;
            st.nmi_fq     <= 1'b1;
            st.nmi_en     <= 1'b0;
            st.clk_main   <= 1'b0;
            st.nonmaskable_debounce_reg       <= `IPP_NONMASKABLE_DEBOUNCE_REG_RESET;
            st.user_stack_pointer        <= `IPP_SP_RESET;
            st.interrupt_stack_pointer        <= `IPP_SP_RESET;
            st.periph_en  <= 1'b1;
            st.cpu_clk_en <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign hrdata         = st.rdata;
    // Zero wait states; every transfer answers OKAY
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign irq_req        = st.irq_req;
    assign irq_num        = st.irq_num;
    assign irq_lvl        = st.irq_lvl;
    assign nmi_req        = st.nmi_req;
    assign cpu_stall      = st.stall;
    assign cpu_clk_en     = st.cpu_clk_en;
    assign periph_clk_en  = st.periph_en;
    assign subclk_div_en  = st.sub_en;
    assign onchip_osc_sel = !st.clk_main;
    assign io_hold        = st.io_hold;
    assign stop_mode      = st.stop;
    assign wait_mode      = st.wait_m;

endmodule : ipp_core
`default_nettype wire

//--- bench/ipp_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ipp_core_assertions (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic irq_req,
    input wire logic nmi_req,
    input wire logic cpu_stall,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic subclk_div_en,
    input wire logic onchip_osc_sel,
    input wire logic io_hold,
    input wire logic stop_mode,
    input wire logic wait_mode
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    stop_gate_a: assert property (
        stop_mode |-> !cpu_clk_en && !periph_clk_en && io_hold)
        else $error("clocks run or ports free in stop");
    wait_hold_a: assert property (
        wait_mode |-> !cpu_clk_en && io_hold)
        else $error("cpu clock or ports free in wait");
    nmi_stall_a: assert property ($rose(nmi_req) |-> cpu_stall)
        else $error("nmi request without stall");
    stall_clk_a: assert property (
        cpu_stall && !stop_mode && !wait_mode |-> cpu_clk_en)
        else $error("stalled cpu lost its clock");
    irq_wake_a: assert property (cpu_stall && irq_req |=> !cpu_stall)
        else $error("stall kept despite interrupt");
    osc_boot_a: assert property ($rose(hresetn) |-> onchip_osc_sel)
        else $error("not on internal oscillator at start");
    sub_pulse_a: assert property (
        subclk_div_en |=> !subclk_div_en [*8])
        else $error("divided clock enable too dense");
    stop_wake_a: assert property (
        stop_mode ##1 irq_req |-> !stop_mode)
        else $error("stop kept despite request");
endmodule : ipp_core_assertions

bind ipp_core ipp_core_assertions u_chk (.hclk(hclk), .hresetn(hresetn),
    .irq_req(irq_req), .nmi_req(nmi_req), .cpu_stall(cpu_stall),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .subclk_div_en(subclk_div_en), .onchip_osc_sel(onchip_osc_sel),
    .io_hold(io_hold), .stop_mode(stop_mode), .wait_mode(wait_mode));
`default_nettype wire

//--- bench/ipp_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module ipp_src_model (
    input wire logic       hclk,
    input wire logic       nmi_req,
    input wire logic       ack_on,
    input wire logic       want_nmi_n,
    input wire logic [7:0] want_src,
    input wire logic       want_wait,
    output logic [7:0]     irq_src,
    output logic           nmi_pin_n,
    output logic           nmi_ack,
    output logic           cpu_wait
);
    int hold_cnt = 0;
    initial begin
        irq_src = 8'h00;
        nmi_pin_n = 1'b1;
        nmi_ack = 1'b0;
        cpu_wait = 1'b0;
    end
    always @(posedge hclk) begin
        irq_src <= want_src;
        cpu_wait <= want_wait;
        hold_cnt <= hold_cnt + 1;
        // Two cycles plus 300 ns at 40 ns is ten cycles
        if (want_nmi_n !== nmi_pin_n && hold_cnt >= 10) begin
            nmi_pin_n <= want_nmi_n;
            hold_cnt <= 0;
        end
        // Slow core leaves the request pending
        nmi_ack <= ack_on && nmi_req && !nmi_ack;
    end
endmodule : ipp_src_model
`default_nettype wire

//--- bench/tb_interrupt_power_protect_logic.sv
`timescale 1ns/1ps
`default_nettype none
`include "ipp_consts.svh"
module tb_interrupt_power_protect_logic;
    import ipp_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rv;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, irq_req, nmi_req, cpu_stall, cpu_clk_en;
    logic periph_clk_en, subclk_div_en, onchip_osc_sel, io_hold;
    logic stop_mode, wait_mode, nmi_pin_n, nmi_ack, cpu_wait;
    ipp_src_t irq_src, want_src = 8'h00;
    ipp_lvl_t irq_num, irq_lvl;
    logic want_nmi_n = 1, want_wait = 0, ack_on = 0;
    int failures = 0, samples_checked = 0, cyc = 0, n;
    initial forever #20 hclk = ~hclk;
    ipp_core uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq_src(irq_src),
        .nmi_pin_n(nmi_pin_n), .nmi_ack(nmi_ack), .cpu_wait(cpu_wait),
        .irq_req(irq_req), .irq_num(irq_num), .irq_lvl(irq_lvl),
        .nmi_req(nmi_req), .cpu_stall(cpu_stall), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en), .subclk_div_en(subclk_div_en),
        .onchip_osc_sel(onchip_osc_sel), .io_hold(io_hold),
        .stop_mode(stop_mode), .wait_mode(wait_mode));
    ipp_src_model u_src (.hclk(hclk), .nmi_req(nmi_req), .ack_on(ack_on),
        .want_nmi_n(want_nmi_n), .want_src(want_src),
        .want_wait(want_wait), .irq_src(irq_src), .nmi_pin_n(nmi_pin_n),
        .nmi_ack(nmi_ack), .cpu_wait(cpu_wait));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [5:0] idx,
                       input logic [31:0] wd);
        haddr <= {24'h0, idx, 2'h0};
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        rv = hrdata;
    endtask : bus
    task automatic test_done;
        $display("Checks %0d, failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done
    task automatic pause(input int c);
        repeat (c) @(posedge hclk);
    endtask : pause
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            test_done();
        end
    end
    initial begin
        pause(16);
        hresetn <= 1;
        @(posedge hclk);
        chk(onchip_osc_sel, 1);
        bus(0, `IPP_OFS_USP, 0); chk(rv, 0);
        bus(0, `IPP_OFS_ISP, 0); chk(rv, 0);
        bus(0, `IPP_OFS_NMIDEB, 0); chk(rv[7:0], `IPP_NONMASKABLE_DEBOUNCE_REG_RESET);
        bus(1, `IPP_OFS_NMIDEB, 3); bus(0, `IPP_OFS_NMIDEB, 0);
        chk(rv[7:0], 3);
        bus(1, `IPP_OFS_NMIDEB, `IPP_NONMASKABLE_DEBOUNCE_REG_BYPASS);
        bus(1, `IPP_OFS_PROTECT, 1); bus(1, 6'h3F, 0);
        bus(1, `IPP_OFS_PMODE2, 32'h10); bus(0, `IPP_OFS_PMODE2, 0);
        chk(rv[4], 0);
        bus(1, `IPP_OFS_PROTECT, 1); bus(1, `IPP_OFS_PMODE2, 32'h10);
        bus(1, `IPP_OFS_PROTECT, 1); bus(1, `IPP_OFS_PMODE2, 0);
        bus(0, `IPP_OFS_PMODE2, 0); chk(rv[4], 1);
        for (n = 0; n < 6; n++) bus(1, `IPP_OFS_ICR0 + 6'(n), 6'h2D >> n);
        want_src <= 8'h03;
        pause(8);
        chk({irq_req, irq_num, irq_lvl}, 7'h4E);
        bus(0, `IPP_OFS_VECTOR, 0); chk(rv[6:0], 7'h61);
        bus(0, `IPP_OFS_VECTOR, 0); chk(rv[6:0], 7'h50);
        bus(0, `IPP_OFS_VECTOR, 0); chk(rv[6:0], 7'h32);
        pause(2); chk(irq_req, 0);
        bus(1, `IPP_OFS_ICR0 + 6'h2, 32'h10); pause(4);
        bus(0, `IPP_OFS_ICR0 + 6'h2, 0); chk(rv[3], 1);
        bus(1, `IPP_OFS_ICR0 + 6'h2, 32'h10);
        bus(0, `IPP_OFS_ICR0 + 6'h2, 0); chk(rv[3], 0);
        want_nmi_n <= 0; pause(16);
        bus(0, `IPP_OFS_PORT8, 0); chk(rv[5], 0);
        chk({nmi_req, cpu_stall}, 2'h3);
        bus(1, `IPP_OFS_CLKCTL1, 1); bus(0, `IPP_OFS_CLKCTL1, 0);
        chk({rv[0], stop_mode}, 0);
        want_src <= 8'h0B; pause(8); chk(cpu_stall, 0);
        bus(0, `IPP_OFS_VECTOR, 0); chk(rv[6:0], 7'h53);
        ack_on <= 1; pause(4); chk(nmi_req, 0);
        want_nmi_n <= 1; pause(16);
        bus(0, `IPP_OFS_PORT8, 0); chk(rv[5], 1);
        bus(1, `IPP_OFS_CLKCTL1, 1); pause(2);
        chk({stop_mode, cpu_clk_en, io_hold}, 3'h5);
        want_src <= 8'h1B; pause(8); chk(stop_mode, 0);
        bus(0, `IPP_OFS_VECTOR, 0); chk(rv[2:0], 4);
        bus(1, `IPP_OFS_CLKCTL0, 32'h04);
        want_wait <= 1; @(posedge hclk); want_wait <= 0; pause(3);
        chk({wait_mode, periph_clk_en, io_hold}, 3'h5);
        n = 0;
        repeat (64) begin
            @(posedge hclk);
            n += int'(subclk_div_en);
        end
        chk(n, 2);
        want_src <= 8'h3B; pause(8); chk({wait_mode, io_hold}, 0);
        bus(0, `IPP_OFS_VECTOR, 0);
        bus(1, `IPP_OFS_CLKCTL0, 32'h80); pause(2);
        chk(onchip_osc_sel, 0);
        bus(1, `IPP_OFS_USP, 32'h1234); bus(0, `IPP_OFS_USP, 0);
        chk(rv, 32'h1234);
        // Second reset in mid-run: sticky bits must fall back
        hresetn <= 0; pause(2); hresetn <= 1; @(posedge hclk);
        chk(onchip_osc_sel, 1);
        bus(0, `IPP_OFS_USP, 0); chk(rv, 0);
        bus(0, `IPP_OFS_PMODE2, 0); chk(rv[4], 0);
        test_done();
    end
endmodule : tb_interrupt_power_protect_logic
`default_nettype wire
